// [logic/hss_top.sv]
// Handler port sequencer with APB registers
//
// Implementation choices: the address map and the APB register port.
`timescale 1ns/1ps
module hss_top #(
    parameter int START_DLY_CYC = hss_pkg::START_MIN_CYC
) (
    input wire logic core_clk,
    input wire logic rstn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [hss_pkg::NLINE-1:0] line_in,
    output logic [hss_pkg::NLINE-1:0] line_out,
    output logic [hss_pkg::NLINE-1:0] line_oe,
    input wire logic external_trigger_in,
    input wire logic panel_lock_n,
    input wire logic pfail_in,
    input wire logic [hss_pkg::NKEY-1:0] panel_keys_in,
    output logic [hss_pkg::NKEY-1:0] panel_keys_out,
    output logic meas_start,
    input wire logic eng_analog_done,
    input wire logic eng_last_analog,
    input wire logic eng_step_done,
    input wire logic eng_cycle_done,
    input wire logic [31:0] eng_primary,
    input wire logic [31:0] eng_secondary,
    input wire logic [hss_pkg::NPT-1:0] eng_point_fail
);
    import hss_pkg::*;

    typedef enum logic [1:0] {ST_IDLE, ST_DELAY, ST_MEAS, ST_UPD} hss_state_t;

    localparam int NSY = NLINE + NKEY + 3;

    function automatic logic is_reg(input logic [7:0] a,
                                    input logic [7:0] off);
        return a == off;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisers
    logic [NSY-1:0] sy1_r;
    logic [NSY-1:0] sy2_r;
    logic trig_d_r;

    wire [NSY-1:0] sy_in = {line_in, panel_keys_in, pfail_in,
                            panel_lock_n, external_trigger_in};
    wire trig_s = sy2_r[0];
    wire lock_s = !sy2_r[1];
    wire pfail_s = sy2_r[2];
    wire [NKEY-1:0] keys_s = sy2_r[NKEY+2:3];
    wire [NLINE-1:0] lines_s = sy2_r[NSY-1:NKEY+3];
    wire trig_rise = trig_s && !trig_d_r;

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            sy1_r <= '0;
            sy2_r <= '0;
            trig_d_r <= 1'b0;
        end else begin
            sy1_r <= sy_in;
            sy2_r <= sy1_r;
            trig_d_r <= trig_s;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // APB slave, zero wait states
    logic [2:0] ctrl_r;
    logic [4:0] lsel_r;
    logic [NLIM-1:0][31:0] lim_r;
    logic [31:0] prdata_r;
    logic pready_r;
    logic pslverr_r;
    logic [31:0] gap_r;
    logic [31:0] lat_r;
    hss_grade_t grade_r;
    hss_state_t st_r;
    hss_state_t st_nxt;
    logic [NLINE-1:0] oe_r;
    logic [NLINE-1:0] out_r;
    logic [NKEY-1:0] keys_r;
    logic meas_start_r;

    wire setup = psel && !penable;
    wire sel_ctrl = is_reg(paddr, A_CTRL);
    wire sel_lsel = is_reg(paddr, A_LSEL);
    wire sel_ldata = is_reg(paddr, A_LDATA);
    wire addr_ok = sel_ctrl || sel_lsel || sel_ldata ||
                   is_reg(paddr, A_STAT) || is_reg(paddr, A_RES) ||
                   is_reg(paddr, A_LINES) || is_reg(paddr, A_LAT);
    wire wr_en = psel && penable && pwrite && pready_r && addr_ok;
    wire lsel_ok = lsel_r < 5'(NLIM);
    wire [31:0] lim_rd = lsel_ok ? lim_r[lsel_r] : 32'h0000_0000;
    wire busy = st_r != ST_IDLE;
    wire [31:0] stat_val = {27'h0, grade_r, pfail_s, lock_s, busy};
    wire [31:0] rd_val =
        sel_ctrl ? {29'h0, ctrl_r} :
        is_reg(paddr, A_STAT) ? stat_val :
        is_reg(paddr, A_RES) ? {15'h0, oe_r} :
        is_reg(paddr, A_LINES) ? {15'h0, lines_s} :
        sel_lsel ? {27'h0, lsel_r} :
        sel_ldata ? lim_rd :
        is_reg(paddr, A_LAT) ? lat_r : 32'h0000_0000;
    wire soft_trig = wr_en && sel_ctrl && pwdata[C_SOFT];

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            prdata_r <= '0;
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
        end else begin
            pready_r <= setup;
            pslverr_r <= setup && !addr_ok;
            if (setup && !pwrite) begin
                prdata_r <= rd_val;
            end
        end
    end

    // Out of range limit slots swallow writes
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            ctrl_r <= CTRL_RST;
            lsel_r <= LSEL_RST;
            lim_r <= {NLIM{LIM_RST}};
        end else begin
            if (wr_en && sel_ctrl) begin
                ctrl_r <= pwdata[2:0];
            end
            if (wr_en && sel_lsel) begin
                lsel_r <= pwdata[4:0];
            end
            if (wr_en && sel_ldata && lsel_ok) begin
                lim_r[lsel_r] <= pwdata;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Measurement sequencer
    wire ext_mode = ctrl_r[C_TRIG_EXT];
    wire list_mode = ctrl_r[C_LIST];
    wire step_mode = ctrl_r[C_LIST] && ctrl_r[C_STEP];
    wire trig_req = ext_mode ? trig_rise : soft_trig;
    wire trig_acc = (st_r == ST_IDLE) && trig_req;
    wire dly_done = gap_r == 32'(START_DLY_CYC - 1);
    wire in_meas = st_r == ST_MEAS;
    wire upd = in_meas && eng_cycle_done;

    always_comb begin
        st_nxt = st_r;
        unique case (st_r)
            ST_IDLE: begin
                if (trig_acc) begin
                    st_nxt = ST_DELAY;
                end
            end
            ST_DELAY: begin
                if (dly_done) begin
                    st_nxt = ST_MEAS;
                end
            end
            ST_MEAS: begin
                if (eng_cycle_done) begin
                    st_nxt = ST_UPD;
                end
            end
            ST_UPD: begin
                st_nxt = ST_IDLE;
            end
        endcase
    end

    // Counter doubles as trigger to result latency
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            st_r <= ST_IDLE;
            gap_r <= '0;
            lat_r <= '0;
            meas_start_r <= 1'b0;
        end else begin
            st_r <= st_nxt;
            meas_start_r <= (st_r == ST_DELAY) && dly_done;
            if (trig_acc) begin
                gap_r <= '0;
            end else if (gap_r != '1) begin
                gap_r <= gap_r + 32'h1;
            end
            if (st_r == ST_UPD) begin
                lat_r <= gap_r;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Comparison and handler lines
    hss_cmp_if cif ();
    hss_level_cmp u_cmp (
        .c(cif.cmp)
    );
    assign cif.prim = eng_primary;
    assign cif.sec = eng_secondary;
    assign cif.lim = lim_r;

    wire lvl_fail = cif.grade == GR_FAIL;
    wire [NBIN-1:0] lvl_bins = lvl_fail ? '0 : cif.bin_hit;
    wire [NBIN-1:0] bins_nxt = list_mode ? eng_point_fail[NBIN-1:0] :
                               lvl_bins;
    wire aux_nxt = list_mode && eng_point_fail[NPT-1];
    wire out_nxt = list_mode ? |eng_point_fail : lvl_fail;
    wire [LN_SECREJ:0] res_nxt = {
        !list_mode && cif.sec_rej,
        !list_mode && cif.lo,
        !list_mode && cif.hi,
        out_nxt, aux_nxt, bins_nxt};

    wire idx_set = in_meas && eng_analog_done &&
                   (!list_mode || step_mode || eng_last_analog);
    wire valid_step = in_meas && step_mode && eng_step_done;
    wire valid_clr = in_meas && step_mode && eng_analog_done;

    // Asserted line means transistor on: enable high, level low
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            oe_r <= '0;
            out_r <= '0;
            grade_r <= GR_PASS;
        end else begin
            out_r <= '0;
            if (upd) begin
                oe_r[LN_SECREJ:0] <= res_nxt;
                grade_r <= cif.grade;
            end
            if (trig_acc) begin
                oe_r[LN_INDEX] <= 1'b0;
            end else if (idx_set) begin
                oe_r[LN_INDEX] <= 1'b1;
            end
            // valid one cycle after results
            // Set wins over a step clear in the same cycle
            if (st_r == ST_UPD || valid_step) begin
                oe_r[LN_VALID] <= 1'b1;
            end else if (trig_acc || valid_clr) begin
                oe_r[LN_VALID] <= 1'b0;
            end
            oe_r[LN_ALARM] <= pfail_s;
        end
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            keys_r <= '0;
        end else begin
            keys_r <= lock_s ? '0 : keys_s;
        end
    end

    assign line_oe = oe_r;
    assign line_out = out_r;
    assign panel_keys_out = keys_r;
    assign meas_start = meas_start_r;
    assign prdata = prdata_r;
    assign pready = pready_r;
    assign pslverr = pslverr_r;

    ////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rstn);

    AST_EXT_EDGE: assert property (
        (st_r == ST_IDLE && ext_mode && trig_rise) |=> st_r == ST_DELAY)
        else $error("external edge did not start a measurement");
    AST_BUSY_IGNORE: assert property (
        (busy && trig_req) |=> gap_r != 32'h0)
        else $error("trigger accepted while busy");
    AST_START_GAP: assert property (
        meas_start_r |-> gap_r == 32'(START_DLY_CYC))
        else $error("measurement start delay wrong");
    AST_STROBE_CLR: assert property (
        trig_acc |=> !oe_r[LN_INDEX] && !oe_r[LN_VALID] &&
                     $stable(oe_r[LN_SECREJ:0]))
        else $error("strobes not cleared or results disturbed");
    AST_VALID_AFTER: assert property (
        ($rose(oe_r[LN_VALID]) && !step_mode) |->
            $past(st_r == ST_UPD) && $past(upd, 2))
        else $error("result valid before comparison outputs");
    AST_INDEX_LVL: assert property (
        (in_meas && eng_analog_done && !list_mode) |=> oe_r[LN_INDEX])
        else $error("analog done not raised");
    AST_PRI_HILO: assert property (
        (upd && !list_mode) |=> oe_r[LN_PRIHI] == $past(cif.hi) &&
                                oe_r[LN_PRILO] == $past(cif.lo))
        else $error("primary high or low flag wrong");
    AST_SEC_REJ: assert property (
        (upd && !list_mode) |=> oe_r[LN_SECREJ] == $past(cif.sec_rej))
        else $error("secondary reject flag wrong");
    AST_LIST_PTS: assert property (
        (upd && list_mode) |=>
            oe_r[LN_AUX:0] == $past(eng_point_fail) &&
            oe_r[LN_OUT] == $past(|eng_point_fail))
        else $error("sweep point lines wrong");
    AST_HOLD: assert property (
        !upd |=> $stable(oe_r[LN_SECREJ:0]))
        else $error("comparison lines moved outside cycle end");
    AST_LOCK: assert property (
        lock_s |=> panel_keys_out == '0)
        else $error("key passed while locked");
    AST_ALARM: assert property (
        pfail_s |=> line_oe[LN_ALARM] && !line_out[LN_ALARM])
        else $error("power fail alert missing");

    CV_LEVEL: cover property (upd && !list_mode && cif.grade == GR_TOL);
    CV_LIST: cover property (upd && list_mode ##2 oe_r[LN_VALID]);
    CV_STEP: cover property (valid_step ##[1:50] valid_clr);
    CV_RETRIG: cover property ($rose(oe_r[LN_VALID]) ##[0:3] trig_acc);
endmodule

// [logic/hss_pkg.sv]
// Constants and types for the handler sort handshake block
package hss_pkg;
    // Clock and timing
    localparam int CLK_KHZ = 40000;
    localparam int TRIG_MIN_US = 1;
    localparam int TRIG_MIN_CYC = (TRIG_MIN_US * CLK_KHZ + 999) / 1000;
    localparam int START_MIN_US = 200;
    localparam int START_MIN_CYC = (START_MIN_US * CLK_KHZ + 999) / 1000;
    localparam int CMP_TYP_US = 1000;
    localparam int CMP_TYP_CYC = CMP_TYP_US * CLK_KHZ / 1000;

    // Sizes
    localparam int NBIN = 9;
    localparam int NPT = 10;
    localparam int NLIM = 20;
    localparam int NLINE = 17;
    localparam int NKEY = 8;

    // Handler line positions
    localparam int LN_BIN0 = 0;
    localparam int LN_AUX = 9;
    localparam int LN_OUT = 10;
    localparam int LN_PRIHI = 11;
    localparam int LN_PRILO = 12;
    localparam int LN_SECREJ = 13;
    localparam int LN_INDEX = 14;
    localparam int LN_VALID = 15;
    localparam int LN_ALARM = 16;

    // Limit table slots
    localparam int LIM_LO0 = 0;
    localparam int LIM_HI0 = 9;
    localparam int LIM_SEC_LO = 18;
    localparam int LIM_SEC_HI = 19;

    // Register offsets
    localparam logic [7:0] A_CTRL = 8'h00;
    localparam logic [7:0] A_STAT = 8'h04;
    localparam logic [7:0] A_RES = 8'h08;
    localparam logic [7:0] A_LINES = 8'h0c;
    localparam logic [7:0] A_LSEL = 8'h10;
    localparam logic [7:0] A_LDATA = 8'h14;
    localparam logic [7:0] A_LAT = 8'h18;

    // Control fields and reset values
    localparam int C_TRIG_EXT = 0;
    localparam int C_LIST = 1;
    localparam int C_STEP = 2;
    localparam int C_SOFT = 3;
    localparam logic [2:0] CTRL_RST = 3'h0;
    localparam logic [4:0] LSEL_RST = 5'h00;
    localparam logic [31:0] LIM_RST = 32'h0000_0000;

    // Status fields
    localparam int S_BUSY = 0;
    localparam int S_LOCK = 1;
    localparam int S_PFAIL = 2;
    localparam int S_GRADE = 3;

    typedef enum logic [1:0] {GR_PASS, GR_TOL, GR_FAIL} hss_grade_t;
endpackage

// [logic/hss_cmp_if.sv]
// Link between the sequencer and the level comparator
`timescale 1ns/1ps
interface hss_cmp_if;
    import hss_pkg::*;
    logic [31:0] prim;
    logic [31:0] sec;
    logic [NLIM-1:0][31:0] lim;
    logic [NBIN-1:0] bin_hit;
    logic hi;
    logic lo;
    logic sec_rej;
    hss_grade_t grade;
    modport cmp (input prim, sec, lim,
                 output bin_hit, hi, lo, sec_rej, grade);
    modport ctl (output prim, sec, lim,
                 input bin_hit, hi, lo, sec_rej, grade);
endinterface

// [logic/hss_level_cmp.sv]
// Level sorting comparator against the nine bin limits
`timescale 1ns/1ps
module hss_level_cmp (
    hss_cmp_if.cmp c
);
    import hss_pkg::*;

    logic [NBIN-1:0] inb;
    logic [NBIN-1:0] abv;
    logic [NBIN-1:0] blw;
    logic [NBIN-1:0] first;

    genvar i;
    generate
        for (i = 0; i < NBIN; i++) begin : g_bin
            assign abv[i] = c.prim > c.lim[LIM_HI0 + i];
            assign blw[i] = c.prim < c.lim[LIM_LO0 + i];
            assign inb[i] = !abv[i] && !blw[i];
        end
    endgenerate

    // Overlapping bins resolve to the lowest one
    assign first = inb & (~inb + NBIN'(1));
    assign c.bin_hit = first;
    assign c.hi = &abv;
    assign c.lo = &blw;
    assign c.sec_rej = (c.sec < c.lim[LIM_SEC_LO]) ||
                    (c.sec > c.lim[LIM_SEC_HI]);
    assign c.grade = (first == '0 || c.sec_rej) ? GR_FAIL :
                     first[0] ? GR_PASS : GR_TOL;
endmodule

// [sim/hss_handler_model.sv]
// Behavioural component handler on the far side of the handler port
`timescale 1ns/1ps
module hss_handler_model
    import hss_pkg::*;
(
    input wire logic core_clk,
    input wire logic rstn,
    input wire logic fire,
    input wire logic [NLINE-1:0] line_in,
    output logic trig,
    output logic [13:0] seen
);
    int hold;
    logic valid_d;
    //////////////////////////////////////////////////////////////////////
    // pulse held one microsecond
    // A fire request during a pulse is dropped, like a busy handler
    always @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            hold <= 0;
            trig <= 1'b0;
        end else if (fire && hold == 0) begin
            hold <= TRIG_MIN_CYC;
            trig <= 1'b1;
        end else if (hold > 1) begin
            hold <= hold - 1;
        end else begin
            hold <= 0;
            trig <= 1'b0;
        end
    end
    //////////////////////////////////////////////////////////////////////
    // sample low pins on valid
    always @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            valid_d <= 1'b0;
            seen <= 14'h0;
        end else begin
            valid_d <= ~line_in[LN_VALID];
            if (~line_in[LN_VALID] && !valid_d) begin
                seen <= ~line_in[13:0];
            end
        end
    end
endmodule

// [sim/testbench.sv]
// Self-checking bench for the handler port sequencer
`timescale 1ns/1ps
module testbench;
    import hss_pkg::*;
    localparam int D = 20;
    typedef struct {logic [31:0] p; logic [31:0] s; logic [13:0] e;} hss_row_t;
    logic core_clk, rstn, psel, penable, pwrite, pready, pslverr, err;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, q, prim, sec;
    logic [NLINE-1:0] line_in, line_out, line_oe;
    logic trig, lock_n, pfail, ms, ad, last, sd, cd, fire;
    logic [NKEY-1:0] keys, keys_o;
    logic [NPT-1:0] pf;
    logic [13:0] seen, prev;
    int miscompares, checked, n;
    // Bin k spans 100(k+1)..100(k+1)+49, secondary 10..20
    hss_row_t rows [8] = '{'{120, 15, 14'h0001}, '{220, 15, 14'h0002},
        '{949, 15, 14'h0100}, '{960, 15, 14'h0c00}, '{50, 15, 14'h1400},
        '{175, 15, 14'h0400}, '{120, 25, 14'h2400}, '{100, 10, 14'h0001}};
    // Open collector lines with pull-ups
    assign line_in = ~line_oe | line_out;
    hss_top #(.START_DLY_CYC(D)) u_dut (.core_clk(core_clk), .rstn(rstn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .line_in(line_in), .line_out(line_out),
        .line_oe(line_oe), .external_trigger_in(trig),
        .panel_lock_n(lock_n), .pfail_in(pfail), .panel_keys_in(keys),
        .panel_keys_out(keys_o), .meas_start(ms), .eng_analog_done(ad),
        .eng_last_analog(last), .eng_step_done(sd), .eng_cycle_done(cd),
        .eng_primary(prim), .eng_secondary(sec), .eng_point_fail(pf));
    hss_handler_model u_handler (.core_clk(core_clk), .rstn(rstn),
        .fire(fire), .line_in(line_in), .trig(trig), .seen(seen));
    initial begin
        core_clk = 1'b0;
        forever #12.5 core_clk = ~core_clk;
    end
    task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
        checked++;
        if (s !== e) begin
            miscompares++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
        end
    endtask
    task conclude;
        $display("checked %0d miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    task hang;
        miscompares++;
        conclude;
    endtask
    //////////////////////////////////////////////////////////////////////
    // Bus master: request held until pready seen at a rising edge
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        n = 0;
        @(posedge core_clk);
        while (pready !== 1'b1 && n < 50) begin
            @(posedge core_clk);
            n++;
        end
        if (n >= 50) hang;
        q = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task wait_start;
        n = 0;
        while (ms !== 1'b1 && n < 200) begin
            @(negedge core_clk);
            n++;
        end
        if (n >= 200) hang;
    endtask
    task meas(input logic [3:0] mode);
        apb(1'b1, A_CTRL, {28'h0, mode});
        wait_start;
    endtask
    // Engine pulse: 0 analog done, 1 step done
    task pulse(input int k, input logic l);
        @(posedge core_clk);
        ad <= (k == 0);
        sd <= (k == 1);
        last <= l;
        @(posedge core_clk);
        ad <= 1'b0;
        sd <= 1'b0;
        @(negedge core_clk);
    endtask
    task finish_cyc(input logic [31:0] p, s, input logic [NPT-1:0] f);
        @(posedge core_clk);
        cd <= 1'b1;
        prim <= p;
        sec <= s;
        pf <= f;
        @(posedge core_clk);
        cd <= 1'b0;
        @(negedge core_clk);
        @(negedge core_clk);
    endtask
    task fire_once;
        @(posedge core_clk);
        fire <= 1'b1;
        @(posedge core_clk);
        fire <= 1'b0;
    endtask
    initial begin
        {psel, penable, pwrite, paddr, pwdata, pfail, ad, last} = '0;
        {sd, cd, fire, prim, sec, pf, keys, rstn} = '0;
        lock_n = 1'b1;
        repeat (20) @(posedge core_clk);
        rstn <= 1'b1;
        @(negedge core_clk);
        chk("oe_reset", line_oe, 0);
        apb(1'b0, A_CTRL, 0);
        chk("ctrl_reset", q[2:0], CTRL_RST);
        apb(1'b0, 8'h40, 0);
        chk("unmapped_err", err, 1);
        for (int i = 0; i < NBIN; i++) begin
            apb(1'b1, A_LSEL, LIM_LO0 + i);
            apb(1'b1, A_LDATA, 100 * (i + 1));
            apb(1'b1, A_LSEL, LIM_HI0 + i);
            apb(1'b1, A_LDATA, 100 * (i + 1) + 49);
        end
        apb(1'b1, A_LSEL, LIM_SEC_LO);
        apb(1'b1, A_LDATA, 10);
        apb(1'b1, A_LSEL, LIM_SEC_HI);
        apb(1'b1, A_LDATA, 20);
        apb(1'b1, A_LSEL, LIM_HI0);
        apb(1'b0, A_LDATA, 0);
        chk("limit_rd", q, 149);
        prev = 14'h0;
        for (int i = 0; i < 8; i++) begin
            meas(4'h8);
            chk("start_dly", n >= D - 1 && n <= D + 2, 1);
            chk("strobes_clr", line_oe[15:14], 0);
            chk("held", line_oe[13:0], prev);
            pulse(0, 1'b0);
            chk("analog_done", line_oe[14], 1);
            chk("eom_early", line_oe[15], 0);
            finish_cyc(rows[i].p, rows[i].s, 0);
            chk("level", line_oe, {3'b011, rows[i].e});
            prev = rows[i].e;
        end
        // List mode, sequential sweep
        meas(4'ha);
        pulse(0, 1'b0);
        chk("idx_mid", line_oe[14], 0);
        pulse(0, 1'b1);
        chk("idx_last", line_oe[14], 1);
        chk("list_hold", line_oe[13:0], prev);
        finish_cyc(0, 0, 10'h201);
        chk("list", line_oe, 17'h0c601);
        apb(1'b0, A_RES, 0);
        chk("res_rd", q, 32'h0000_c601);
        // Stepping sweep
        meas(4'he);
        pulse(0, 1'b0);
        chk("step_idx", line_oe[14], 1);
        pulse(1, 1'b0);
        chk("step_eom", line_oe[15], 1);
        pulse(0, 1'b0);
        chk("step_eom_clr", line_oe[15], 0);
        finish_cyc(0, 0, 0);
        chk("step_end", line_oe, 17'h0c000);
        // External trigger through the handler
        apb(1'b1, A_CTRL, 1);
        fire_once;
        wait_start;
        chk("ext_start", ms, 1);
        repeat (45) @(negedge core_clk);
        fire_once;
        n = 0;
        repeat (80) begin
            @(negedge core_clk);
            n += ms;
        end
        chk("busy_trig", n, 0);
        pulse(0, 1'b0);
        finish_cyc(120, 15, 0);
        @(negedge core_clk);
        chk("handler_seen", seen, 14'h0001);
        fire_once;
        wait_start;
        chk("retrigger", ms, 1);
        // Keys, lock and supply alarm
        @(posedge core_clk);
        keys <= 8'ha5;
        repeat (5) @(negedge core_clk);
        chk("keys", keys_o, 8'ha5);
        @(posedge core_clk);
        lock_n <= 1'b0;
        pfail <= 1'b1;
        repeat (5) @(negedge core_clk);
        chk("keys_locked", keys_o, 0);
        chk("alarm", line_oe[LN_ALARM], 1);
        chk("alarm_pin", {line_out[LN_ALARM], line_in[LN_ALARM]}, 0);
        conclude;
    end
endmodule
